/* File: rtl/scb_pkg.sv */
// Constants and carrier types for the system control register bank.
// Assumes an 8-bit processor core on a special function bus with byte addresses.
// Summary of operation
// - Writing one to a user port data bit drives its pin high and writing zero holds it low.
// - Each user port direction bit sets its pin as output when zero and as input when one.
// - The user port data register covers eight pins, reads return pin levels and writes set output values.
// - The processor clock is the PLL clock divided by two times the divider field plus one.
// - After reset the divider field holds twelve.
// - With wake routing set, keypad, card and user pin interrupts all raise interrupt line zero.
// - Under wake routing, line zero is asserted 512 processor clocks after the source event.
// - Any read of the wake interrupt control register clears the wake routing bit.
// - The wake interrupt control register resets to all zeros.
// - The oscillator and PLL are disabled 32 processor clocks after the power-down bit is set.
`default_nettype none

package scb_pkg;
  localparam logic [15:0] ADDR_USER_PORT_DATA = 16'h0090;
  localparam logic [15:0] ADDR_USER_PORT_DIR = 16'h0091;
  localparam logic [15:0] ADDR_WAKE_IRQ_CTRL = 16'hff94;
  localparam logic [15:0] ADDR_CLK_DIV = 16'hffa1;

  localparam logic [7:0] USER_DATA_RESET = 8'h00;
  localparam logic [7:0] USER_DIR_RESET = 8'hff;
  localparam logic [5:0] CLK_DIV_RESET = 6'h0c;

  localparam int WAKE_ROUTE_BIT = 7;
  localparam int KEYPAD_EN_BIT = 1;
  localparam int KEYPAD_FLAG_BIT = 0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_DELAY_CYCLES = 512;
  localparam int POWER_DOWN_REQUEST_DELAY_CYCLES = 32;

  typedef struct packed {
    logic keypad;
    logic card;
    logic user_pins;
  } scb_irq_src_t;

  typedef struct packed {
    logic line_zero;
    logic line_four;
    logic line_five;
  } scb_irq_out_t;
endpackage : scb_pkg

`default_nettype wire

/* File: rtl/scb_sfr_bank.sv */
// Special function registers for user port, processor clock divider and wake interrupt routing.
// Assumes one clock; the processor core gives a one-cycle read or write strobe with address and data.
`default_nettype none

module scb_sfr_bank (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic pll_clk_en_i,
  output logic processor_clock_en_o,
  input wire logic [7:0] user_pin_i,
  output logic [7:0] user_pin_o,
  output logic [7:0] user_pin_oe_n_o,
  input wire scb_pkg::scb_irq_src_t irq_src_i,
  input wire logic keypad_event_i,
  input wire logic power_down_request_i,
  output scb_pkg::scb_irq_out_t irq_o,
  output logic analog_disable_o
);

  // Pin levels cross from outside the clock domain
  logic [7:0] pin_meta_q, pin_sync_q;
  scb_pkg::scb_irq_src_t src_meta_q, src_sync_q;

  logic [7:0] user_port_data_q, user_port_data_d;
  logic [7:0] user_port_direction_q, user_port_direction_d;
  logic [5:0] clock_divide_field_q, clock_divide_field_d;
  logic wake_routing_enable_q, wake_routing_enable_d;
  logic keypad_irq_enable_q, keypad_irq_enable_d;
  logic keypad_irq_flag_q, keypad_irq_flag_d;
  logic [7:0] rdata_q, rdata_d;

  logic [6:0] pll_cnt_q, pll_cnt_d;
  logic proc_en_q, proc_en_d;

  typedef enum {SCB_IDLE, SCB_WAIT} scb_wake_state_t;
  scb_wake_state_t wake_state_q, wake_state_d;
  logic [9:0] wake_cnt_q, wake_cnt_d;
  logic line_zero_q, line_zero_d;

  logic power_down_request_seen_q, power_down_request_seen_d;
  logic [5:0] power_down_request_cnt_q, power_down_request_cnt_d;
  logic analog_off_q, analog_off_d;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : hit

  always_ff @(posedge core_clk_i) begin
    pin_meta_q <= user_pin_i;
    pin_sync_q <= pin_meta_q;
    src_meta_q <= irq_src_i;
    src_sync_q <= src_meta_q;
  end

  // Register file
  always_comb begin
    user_port_data_d = user_port_data_q;
    user_port_direction_d = user_port_direction_q;
    clock_divide_field_d = clock_divide_field_q;
    wake_routing_enable_d = wake_routing_enable_q;
    keypad_irq_enable_d = keypad_irq_enable_q;
    keypad_irq_flag_d = keypad_irq_flag_q;
    rdata_d = 8'h00;
    if (sfr_wr_i) begin
      if (hit(sfr_addr_i, scb_pkg::ADDR_USER_PORT_DATA)) begin
        user_port_data_d = sfr_wdata_i;
      end
      if (hit(sfr_addr_i, scb_pkg::ADDR_USER_PORT_DIR)) begin
        user_port_direction_d = sfr_wdata_i;
      end
      if (hit(sfr_addr_i, scb_pkg::ADDR_CLK_DIV)) begin
        clock_divide_field_d = sfr_wdata_i[5:0];
      end
      if (hit(sfr_addr_i, scb_pkg::ADDR_WAKE_IRQ_CTRL)) begin
        wake_routing_enable_d = sfr_wdata_i[scb_pkg::WAKE_ROUTE_BIT];
        keypad_irq_enable_d = sfr_wdata_i[scb_pkg::KEYPAD_EN_BIT];
        keypad_irq_flag_d = sfr_wdata_i[scb_pkg::KEYPAD_FLAG_BIT];
      end
    end
    if (sfr_rd_i) begin
      if (hit(sfr_addr_i, scb_pkg::ADDR_USER_PORT_DATA)) begin
        rdata_d = pin_sync_q;
      end
      if (hit(sfr_addr_i, scb_pkg::ADDR_USER_PORT_DIR)) begin
        rdata_d = user_port_direction_q;
      end
      if (hit(sfr_addr_i, scb_pkg::ADDR_CLK_DIV)) begin
        rdata_d = {2'b00, clock_divide_field_q};
      end
      if (hit(sfr_addr_i, scb_pkg::ADDR_WAKE_IRQ_CTRL)) begin
        rdata_d = 8'h00;
        rdata_d[scb_pkg::WAKE_ROUTE_BIT] = wake_routing_enable_q;
        rdata_d[scb_pkg::KEYPAD_EN_BIT] = keypad_irq_enable_q;
        rdata_d[scb_pkg::KEYPAD_FLAG_BIT] = keypad_irq_flag_q;
        wake_routing_enable_d = 1'b0;
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (keypad_event_i) begin
      keypad_irq_flag_d = 1'b1;
    end
    if (!rst_n_i) begin
      user_port_data_d = scb_pkg::USER_DATA_RESET;
      user_port_direction_d = scb_pkg::USER_DIR_RESET;
      clock_divide_field_d = scb_pkg::CLK_DIV_RESET;
      wake_routing_enable_d = 1'b0;
      keypad_irq_enable_d = 1'b0;
      keypad_irq_flag_d = 1'b0;
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk_i) begin
    user_port_data_q <= user_port_data_d;
    user_port_direction_q <= user_port_direction_d;
    clock_divide_field_q <= clock_divide_field_d;
    wake_routing_enable_q <= wake_routing_enable_d;
    keypad_irq_enable_q <= keypad_irq_enable_d;
    keypad_irq_flag_q <= keypad_irq_flag_d;
    rdata_q <= rdata_d;
  end

  // Divider: one enable pulse per 2*(field+1) PLL enables; zero and one are not guarded
  always_comb begin
    pll_cnt_d = pll_cnt_q;
    proc_en_d = 1'b0;
    if (pll_clk_en_i) begin
      if (pll_cnt_q >= {clock_divide_field_q, 1'b1}) begin
        pll_cnt_d = 7'h00;
        proc_en_d = 1'b1;
      end else begin
        pll_cnt_d = pll_cnt_q + 7'h01;
      end
    end
    if (!rst_n_i) begin
      pll_cnt_d = 7'h00;
      proc_en_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    pll_cnt_q <= pll_cnt_d;
    proc_en_q <= proc_en_d;
  end

  // Wake routing: any source starts a settling delay, then line zero rises
  logic any_src;
  assign any_src = src_sync_q.keypad | src_sync_q.card | src_sync_q.user_pins;

  always_comb begin
    wake_state_d = wake_state_q;
    wake_cnt_d = wake_cnt_q;
    line_zero_d = 1'b0;
    case (wake_state_q)
      SCB_IDLE: begin
        wake_cnt_d = 10'h000;
        if (wake_routing_enable_q && any_src) begin
          wake_state_d = SCB_WAIT;
        end
      end
      SCB_WAIT: begin
        if (processor_clock_en_o) begin
          wake_cnt_d = wake_cnt_q + 10'h001;
        end
        if (wake_cnt_q == 10'(scb_pkg::WAKE_DELAY_CYCLES - 1) && processor_clock_en_o) begin
          line_zero_d = 1'b1;
          wake_state_d = SCB_IDLE;
        end
      end
      default: wake_state_d = SCB_IDLE;
    endcase
    if (!rst_n_i) begin
      wake_state_d = SCB_IDLE;
      wake_cnt_d = 10'h000;
      line_zero_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    wake_state_q <= wake_state_d;
    wake_cnt_q <= wake_cnt_d;
    line_zero_q <= line_zero_d;
  end

  // Power down: analog shutoff after 32 processor clocks, held until reset
  always_comb begin
    power_down_request_seen_d = power_down_request_seen_q | power_down_request_i;
    power_down_request_cnt_d = power_down_request_cnt_q;
    analog_off_d = analog_off_q;
    if (power_down_request_seen_q && !analog_off_q && processor_clock_en_o) begin
      if (power_down_request_cnt_q == 6'(scb_pkg::POWER_DOWN_REQUEST_DELAY_CYCLES - 1)) begin
        analog_off_d = 1'b1;
      end else begin
        power_down_request_cnt_d = power_down_request_cnt_q + 6'h01;
      end
    end
    if (!rst_n_i) begin
      power_down_request_seen_d = 1'b0;
      power_down_request_cnt_d = 6'h00;
      analog_off_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    power_down_request_seen_q <= power_down_request_seen_d;
    power_down_request_cnt_q <= power_down_request_cnt_d;
    analog_off_q <= analog_off_d;
  end

  always_comb begin
    sfr_rdata_o = rdata_q;
    processor_clock_en_o = proc_en_q;
    user_pin_o = user_port_data_q;
    user_pin_oe_n_o = user_port_direction_q;
    analog_disable_o = analog_off_q;
    irq_o.line_zero = wake_routing_enable_q ? line_zero_q : src_sync_q.user_pins;
    irq_o.line_four = src_sync_q.card & ~wake_routing_enable_q;
    irq_o.line_five = (keypad_irq_flag_q & keypad_irq_enable_q) & ~wake_routing_enable_q;
  end

endmodule : scb_sfr_bank

`default_nettype wire

/* File: tb/scb_core_model.sv */
// Behavioural processor core issuing single-cycle strobes on the special function bus.
// Assumes the bench clock; signals change on the falling edge only.
`default_nettype none
module scb_core_model (
  input wire logic core_clk_i,
  input wire logic [7:0] sfr_rdata_o,
  output logic [15:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr_o = 16'h0000;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_i);
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = w;
    sfr_rd_o = !w;
    @(negedge core_clk_i);
    q = sfr_rdata_o;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    // Released lines flip so a stale value never passes for a live one
    sfr_addr_o = ~a;
    sfr_wdata_o = ~d;
  endtask : xfer
endmodule : scb_core_model
`default_nettype wire

/* File: tb/scb_sfr_bank_monitor.sv */
// Port assertions for the system control register bank.
// Assumes binding into scb_sfr_bank; one clock, synchronous active-low reset.
`default_nettype none
module scb_sfr_bank_monitor (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] user_pin_o,
  input wire logic [7:0] user_pin_oe_n_o,
  input wire logic processor_clock_en_o,
  input wire logic power_down_request_i,
  input wire logic analog_disable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle; !sfr_rd_i |=> sfr_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_pin; sfr_wr_i && sfr_addr_i == 16'h0090 |-> ##2 user_pin_o == $past(sfr_wdata_i, 2); endproperty
  a_pin: assert property (p_pin) else $error("pin level differs from write");
  property p_dir; sfr_wr_i && sfr_addr_i == 16'h0091 |-> ##2 user_pin_oe_n_o == $past(sfr_wdata_i, 2); endproperty
  a_dir: assert property (p_dir) else $error("direction differs from write");
  property p_div_top; sfr_rd_i && sfr_addr_i == 16'hffa1 |=> sfr_rdata_o[7:6] == 2'h0; endproperty
  a_div_top: assert property (p_div_top) else $error("divider top bits set");
  property p_wake_mid; sfr_rd_i && sfr_addr_i == 16'hff94 |=> sfr_rdata_o[6:2] == 5'h00; endproperty
  a_wake_mid: assert property (p_wake_mid) else $error("wake control unused bits set");
  property p_clk_gap; processor_clock_en_o |=> (!processor_clock_en_o) [*5]; endproperty
  a_clk_gap: assert property (p_clk_gap) else $error("processor clock too fast");
  property p_pd_hold; analog_disable_o |=> analog_disable_o; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("analog disable dropped");
  property p_pd_early; $rose(power_down_request_i) && !analog_disable_o |=> (!analog_disable_o) [*8]; endproperty
  a_pd_early: assert property (p_pd_early) else $error("analog disabled early");
  property p_reset; disable iff (1'b0) !rst_n_i |=> user_pin_oe_n_o == 8'hff && user_pin_o == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("pin reset state wrong");
endmodule : scb_sfr_bank_monitor
bind scb_sfr_bank scb_sfr_bank_monitor u_mon (.core_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_wdata_i, .sfr_rdata_o, .user_pin_o, .user_pin_oe_n_o, .processor_clock_en_o, .power_down_request_i,
  .analog_disable_o);
`default_nettype wire

/* File: tb/scb_sfr_bank_tb_top.sv */
// Self-checking bench for the system control register bank.
// Assumes the core model drives the bus; pins and sources change on falling edges.
`default_nettype none
module scb_sfr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] sfr_addr_i;
  logic sfr_wr_i, sfr_rd_i, processor_clock_en_o, analog_disable_o;
  logic [7:0] sfr_wdata_i, sfr_rdata_o, user_pin_o, user_pin_oe_n_o, q;
  logic [7:0] user_pin_i = 8'h00;
  logic pll_clk_en_i = 1'b1, keypad_event_i = 1'b0, power_down_request_i = 1'b0;
  scb_pkg::scb_irq_src_t irq_src_i = '0;
  scb_pkg::scb_irq_out_t irq_o;
  int err_total = 0, samples_checked = 0, pulses = 0;
  // Tasks take a snapshot instead of clearing, so only the clocked counter writes pulses
  int mark = 0;
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (processor_clock_en_o === 1'b1) pulses <= pulses + 1;
  scb_core_model u_core (.core_clk_i, .sfr_rdata_o, .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
    .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i));
  scb_sfr_bank DUT (.core_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .pll_clk_en_i, .processor_clock_en_o, .user_pin_i, .user_pin_o, .user_pin_oe_n_o, .irq_src_i,
    .keypad_event_i, .power_down_request_i, .irq_o, .analog_disable_o);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_core.xfer(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    u_core.xfer(a, 1'b0, 8'h00, q);
  endtask : rd
  task automatic t_reset;
    rd(16'hffa1);
    chk(q, 8'h0c);
    rd(16'hff94);
    chk(q, 8'h00);
  endtask : t_reset
  task automatic t_port;
    wr(16'h0090, 8'ha5);
    wr(16'h0091, 8'h0f);
    user_pin_i = 8'h3c;
    repeat (3) @(negedge core_clk_i);
    chk(user_pin_o, 8'ha5);
    chk(user_pin_oe_n_o, 8'h0f);
    rd(16'h0090);
    chk(q, 8'h3c);
    rd(16'h0099);
    chk(q, 8'h00);
  endtask : t_port
  task automatic t_div;
    wr(16'hffa1, 8'hff);
    rd(16'hffa1);
    chk(q, 8'h3f);
    // Field kept at two or more
    wr(16'hffa1, 8'h02);
    repeat (24) @(negedge core_clk_i);
    mark = pulses;
    repeat (60) @(negedge core_clk_i);
    chk(16'(pulses - mark), 16'd10);
  endtask : t_div
  task automatic t_wake;
    wr(16'hff94, 8'h82);
    rd(16'hff94);
    chk(q, 8'h82);
    rd(16'hff94);
    chk(q, 8'h02);
    keypad_event_i = 1'b1;
    @(negedge core_clk_i);
    keypad_event_i = 1'b0;
    rd(16'hff94);
    chk(q, 8'h03);
    chk(irq_o, 3'b001);
    wr(16'hff94, 8'h80);
    irq_src_i.card = 1'b1;
    mark = pulses;
    repeat (4) @(negedge core_clk_i);
    chk(irq_o, 3'b000);
    for (int i = 0; i < 4000 && irq_o.line_zero !== 1'b1; i++) @(negedge core_clk_i);
    chk(16'((pulses - mark) >= 511 && (pulses - mark) <= 513), 16'h1);
    // Reading drops routing, so the card source falls back to its own line
    rd(16'hff94);
    chk(q, 8'h80);
    chk(irq_o, 3'b010);
    irq_src_i.card = 1'b0;
  endtask : t_wake
  task automatic t_pd;
    // Routing armed ahead of power-down
    wr(16'hff94, 8'h80);
    mark = pulses;
    power_down_request_i = 1'b1;
    for (int i = 0; i < 400 && analog_disable_o !== 1'b1; i++) @(negedge core_clk_i);
    chk(16'((pulses - mark) >= 31 && (pulses - mark) <= 33), 16'h1);
  endtask : t_pd
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_reset;
    t_port;
    t_div;
    t_wake;
    t_pd;
    conclude;
  end
  // Whole run needs about 4000 cycles; twice that means a hang
  initial begin
    #80us;
    err_total++;
    conclude;
  end
endmodule : scb_sfr_bank_tb_top
`default_nettype wire
